// [hw/cpu_ctrl_regs.vh]
// control register indices, field positions, reset values and fault codes
`ifndef CPU_CTRL_REGS_VH
`define CPU_CTRL_REGS_VH

// register selects used by the move-to/from control register ports
`define SEL_SYSCTL       3'h0
`define SEL_PAGEBASE     3'h3
`define SEL_EXTCTL       3'h4

// system control word fields
`define SC_PROT          0
`define SC_WAITTS        1
`define SC_FPTRAP        2
`define SC_TSW           3
`define SC_NUMERR        5
`define SC_WPROT         16
`define SC_ALIGN         18
`define SC_WTOFF         29
`define SC_CACHEOFF      30
`define SC_PAGING        31
`define SC_WMASK         32'he005002f
`define SC_RESET         32'h60000000

// page base control fields
`define PB_WTHRU         3
`define PB_CINH          4
`define PB_WMASK         32'hfffff018
`define PB_RESET         32'h00000000

// extension control fields
`define EX_V86VI         0
`define EX_PVI           1
`define EX_TSR           2
`define EX_BRK           3
`define EX_LPAGE         4
`define EX_WIDE          5
`define EX_HWERR         6
`define EX_GLOBAL        7
`define EX_PERF          8
`define EX_WMASK         32'h000001ff
`define EX_RESET         32'h00000000

// fault vectors
`define VEC_UNDEF        8'h06
`define VEC_NODEV        8'h07
`define VEC_GPROT        8'h0d
`define VEC_MCHK         8'h12

// floating-point control word seen after initialisation
`define FCW_ABSENT       16'hffff
`define FCW_PRESENT      16'h037f

// page size codes and address widths
`define PG_SMALL         2'h0
`define PG_4M            2'h1
`define PG_2M            2'h2
`define ADDR_NARROW      6'h20
`define ADDR_WIDE        6'h24

// debug register numbers refused under the extension
`define DBG_FOUR         3'h4
`define DBG_FIVE         3'h5
`define CPL_TOP          2'h0

`endif

// [hw/processor_control_flag_bank.v]
// processor control flag bank: three control registers and their gating
//
// Behaviour
// - fp-trap flag set traps fp instructions; with it and task-switched flag clear they go to fpu
// - wait-check flag makes waiting instructions test task-switched flag
// - emulated fp instructions raise device-not-available fault vector 7
// - fp control word reads ffff without coprocessor, 037f with one
// - wide-address flag bit 5 gives 36-bit addresses, else 32-bit
// - wide addressing only with paging on, using the wide table format
// - global-keep flag bit 7 spares global tlb entries on flushes
// - task switch or page-base write flushes tlb except kept globals
// - perf-counter flag bit 8 opens counter read at every level
// - hardware reset clears extension control register to zero
// - timestamp restrict flag allows timestamp read at level 0 only
// - breakpoint extension makes debug register four/five undefined opcode
// - large-page flag bit 4: 4M pages, or 2M with wide addressing
// - two flags enable virtual interrupt flag in v86 and protected mode
// - hardware-error enable flag lets machine-check exceptions through
// - numeric-error flag selects internal numeric error reporting
// - write-protect blocks supervisor writes to read-only user pages
// - alignment checked only when gate flag and flags-register bit set
// - write-through-off suppresses invalidations and hit write-throughs
// - cache-off flag disables the internal cache
// - page-level cache bits drive hint pins on non-paged cycles while paging is on
// - wide addressing, global and large pages need protected mode
`include "cpu_ctrl_regs.vh"

module processor_control_flag_bank (
  // clock, reset, enable
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  // control register move port
  input  wire        crWrEn,
  input  wire [2:0]  crWrSel,
  input  wire [31:0] crWrData,
  input  wire [2:0]  crRdSel,
  output reg  [31:0] crRdData,
  // instruction check request
  input  wire        insnValid,
  input  wire        insnFp,
  input  wire        insnWait,
  input  wire        insnPerfRead,
  input  wire        insnTimeRead,
  input  wire        insnDebugRef,
  input  wire [2:0]  insnDebugNum,
  input  wire [1:0]  insnCpl,
  output reg         fpDispatch,
  output reg         faultValid,
  output reg  [7:0]  faultVector,
  // core events
  input  wire        taskSwitch,
  input  wire        alignCheckFlag,
  input  wire        fpNumericErr,
  output reg         fpErrInternal,
  output reg         fpErrExternal,
  // page access check
  input  wire        accValid,
  input  wire        accWrite,
  input  wire        accSuper,
  input  wire        accUserPage,
  input  wire        accReadOnly,
  output reg         accBlocked,
  // bus cycle hints
  input  wire        nonPagedCycle,
  input  wire        pageCacheInhibit,
  input  wire        pageWriteThrough,
  output reg         extCacheInhibitPin,
  output reg         extWriteThroughPin,
  // external pins
  input  wire        coproPresentPin,
  input  wire        hwErrorPin,
  output reg  [15:0] fpCtrlWordInit,
  // derived configuration
  output reg         tlbFlush,
  output reg         tlbKeepGlobal,
  output wire [5:0]  physAddrBits,
  output wire        wideTableFormat,
  output wire [1:0]  pageSizeMode,
  output wire        cacheEnable,
  output wire        invalidateEnable,
  output wire        hitWriteThrough,
  output wire        alignCheckOn,
  output wire        v86VirtIntOn,
  output wire        protVirtIntOn
);

  reg [31:0] sysCtl_q;
  reg [31:0] pageBase_q;
  reg [31:0] extCtl_q;
  reg [1:0]  coproSync_q;
  reg [1:0]  hwErrSync_q;
  reg        hwErrSeen_q;
  reg        tsSet;
  reg        sysWr;
  reg        sysBad;
  reg [31:0] sysCtl_d;
  reg        chkFault;
  reg [7:0]  chkVec;
  reg        chkDispatch;
  wire       mchkEdge;

  // feature needing protected mode and paging
  function feat;
    input f;
    input [31:0] sc;
    begin
      feat = f & sc[`SC_PROT] & sc[`SC_PAGING];
    end
  endfunction

  // merge writable bits of a write into a register
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] val;
    input [31:0] msk;
    begin
      wmerge = (old & ~msk) | (val & msk);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  always @* begin
    sysWr = crWrEn & (crWrSel == `SEL_SYSCTL);
    // cache on with write-through off is an invalid combination
    sysBad = sysWr & ~crWrData[`SC_CACHEOFF] & crWrData[`SC_WTOFF];
    tsSet = taskSwitch;
    sysCtl_d = sysCtl_q;
    if (sysWr & ~sysBad) begin
      sysCtl_d = wmerge(sysCtl_q, crWrData, `SC_WMASK);
    end
    if (tsSet) begin
      sysCtl_d[`SC_TSW] = 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sysCtl_q <= `SC_RESET;
      pageBase_q <= `PB_RESET;
      extCtl_q <= `EX_RESET;
    end else if (ce) begin
      sysCtl_q <= sysCtl_d;
      if (crWrEn & (crWrSel == `SEL_PAGEBASE)) begin
        pageBase_q <= wmerge(pageBase_q, crWrData, `PB_WMASK);
      end
      if (crWrEn & (crWrSel == `SEL_EXTCTL)) begin
        extCtl_q <= wmerge(extCtl_q, crWrData, `EX_WMASK);
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      crRdData <= 32'h00000000;
    end else if (ce) begin
      case (crRdSel)
        `SEL_SYSCTL:   crRdData <= sysCtl_q;
        `SEL_PAGEBASE: crRdData <= pageBase_q;
        `SEL_EXTCTL:   crRdData <= extCtl_q;
        default:       crRdData <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      coproSync_q <= 2'h0;
      hwErrSync_q <= 2'h0;
      hwErrSeen_q <= 1'b0;
    end else if (ce) begin
      coproSync_q <= {coproSync_q[0], coproPresentPin};
      hwErrSync_q <= {hwErrSync_q[0], hwErrorPin};
      hwErrSeen_q <= hwErrSync_q[1];
    end
  end

  assign mchkEdge = hwErrSync_q[1] & ~hwErrSeen_q;

  ////////////////////////////////////////////////////////////////////////////
  // instruction checks

  always @* begin
    chkFault = 1'b0;
    chkVec = `VEC_GPROT;
    chkDispatch = 1'b0;
    if (insnFp) begin
      if (sysCtl_q[`SC_FPTRAP] | sysCtl_q[`SC_TSW]) begin
        chkFault = 1'b1;
        chkVec = `VEC_NODEV;
      end else begin
        chkDispatch = 1'b1;
      end
    end else if (insnWait) begin
      if (sysCtl_q[`SC_WAITTS] & sysCtl_q[`SC_TSW]) begin
        chkFault = 1'b1;
        chkVec = `VEC_NODEV;
      end
    end else if (insnPerfRead) begin
      chkFault = ~extCtl_q[`EX_PERF] & (insnCpl != `CPL_TOP);
    end else if (insnTimeRead) begin
      chkFault = extCtl_q[`EX_TSR] & (insnCpl != `CPL_TOP);
    end else if (insnDebugRef) begin
      if (extCtl_q[`EX_BRK] & ((insnDebugNum == `DBG_FOUR) |
                               (insnDebugNum == `DBG_FIVE))) begin
        chkFault = 1'b1;
        chkVec = `VEC_UNDEF;
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fpDispatch <= 1'b0;
      faultValid <= 1'b0;
      faultVector <= 8'h00;
    end else if (ce) begin
      fpDispatch <= insnValid & chkDispatch;
      faultValid <= 1'b0;
      if (mchkEdge & extCtl_q[`EX_HWERR]) begin
        faultValid <= 1'b1;
        faultVector <= `VEC_MCHK;
      end else if (sysBad) begin
        faultValid <= 1'b1;
        faultVector <= `VEC_GPROT;
      end else if (insnValid & chkFault) begin
        faultValid <= 1'b1;
        faultVector <= chkVec;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access, error, hint and flush outputs

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      accBlocked <= 1'b0;
      fpErrInternal <= 1'b0;
      fpErrExternal <= 1'b0;
      extCacheInhibitPin <= 1'b0;
      extWriteThroughPin <= 1'b0;
      fpCtrlWordInit <= `FCW_ABSENT;
      tlbFlush <= 1'b0;
      tlbKeepGlobal <= 1'b0;
    end else if (ce) begin
      accBlocked <= accValid & accWrite & accReadOnly &
                    (~accSuper | (accUserPage & sysCtl_q[`SC_WPROT]));
      fpErrInternal <= fpNumericErr & sysCtl_q[`SC_NUMERR];
      fpErrExternal <= fpNumericErr & ~sysCtl_q[`SC_NUMERR];
      if (nonPagedCycle & sysCtl_q[`SC_PAGING]) begin
        extCacheInhibitPin <= pageBase_q[`PB_CINH];
        extWriteThroughPin <= pageBase_q[`PB_WTHRU];
      end else begin
        extCacheInhibitPin <= pageCacheInhibit;
        extWriteThroughPin <= pageWriteThrough;
      end
      fpCtrlWordInit <= coproSync_q[1] ? `FCW_PRESENT : `FCW_ABSENT;
      // flush on switch or page base write
      tlbFlush <= taskSwitch | (crWrEn & (crWrSel == `SEL_PAGEBASE));
      tlbKeepGlobal <= feat(extCtl_q[`EX_GLOBAL], sysCtl_q);
    end
  end

  assign physAddrBits = feat(extCtl_q[`EX_WIDE], sysCtl_q) ?
                        `ADDR_WIDE : `ADDR_NARROW;
  assign wideTableFormat = feat(extCtl_q[`EX_WIDE], sysCtl_q);
  assign pageSizeMode = ~feat(extCtl_q[`EX_LPAGE], sysCtl_q) ? `PG_SMALL :
                        wideTableFormat ? `PG_2M : `PG_4M;
  assign cacheEnable = ~sysCtl_q[`SC_CACHEOFF];
  assign invalidateEnable = ~sysCtl_q[`SC_WTOFF];
  assign hitWriteThrough = ~sysCtl_q[`SC_WTOFF];
  assign alignCheckOn = sysCtl_q[`SC_ALIGN] & alignCheckFlag;
  assign v86VirtIntOn = extCtl_q[`EX_V86VI];
  assign protVirtIntOn = extCtl_q[`EX_PVI];

endmodule // processor_control_flag_bank

// [test/flag_bank_sva.sv]
// assertion checker for the control flag bank ports
`include "cpu_ctrl_regs.vh"

module flag_bank_sva (
  // clock and reset
  input logic       clk,
  input logic       rst,
  input logic       ce,
  // requests
  input logic       crWrEn,
  input logic [2:0] crWrSel,
  input logic       insnValid,
  input logic       insnFp,
  input logic       taskSwitch,
  input logic       nonPagedCycle,
  input logic       pageCacheInhibit,
  input logic       pageWriteThrough,
  // results
  input logic       fpDispatch,
  input logic       faultValid,
  input logic       tlbFlush,
  input logic       extCacheInhibitPin,
  input logic       extWriteThroughPin,
  input logic [5:0] physAddrBits,
  input logic       wideTableFormat,
  input logic [1:0] pageSizeMode,
  input logic       invalidateEnable,
  input logic       hitWriteThrough
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_fpAns;
    ce && insnValid && insnFp |=> fpDispatch || faultValid;
  endproperty
  a_fpAns: assert property (p_fpAns)
    else $error("fp instruction got no answer");

  property p_fpSrc;
    fpDispatch |-> $past(ce && insnValid && insnFp);
  endproperty
  a_fpSrc: assert property (p_fpSrc)
    else $error("dispatch without fp instruction");

  property p_width;
    wideTableFormat ? physAddrBits == `ADDR_WIDE
                    : physAddrBits == `ADDR_NARROW;
  endproperty
  a_width: assert property (p_width)
    else $error("address width wrong");

  property p_psize;
    pageSizeMode != `PG_SMALL |->
      (pageSizeMode == `PG_2M) == wideTableFormat;
  endproperty
  a_psize: assert property (p_psize)
    else $error("page size mode wrong");

  property p_nw;
    invalidateEnable == hitWriteThrough;
  endproperty
  a_nw: assert property (p_nw)
    else $error("write-through and invalidation differ");

  property p_flushTs;
    ce && taskSwitch |=> tlbFlush;
  endproperty
  a_flushTs: assert property (p_flushTs)
    else $error("no flush on task switch");

  property p_flushPb;
    ce && crWrEn && crWrSel == `SEL_PAGEBASE |=> tlbFlush;
  endproperty
  a_flushPb: assert property (p_flushPb)
    else $error("no flush on page base write");

  property p_hint;
    ce && !nonPagedCycle |=>
      {extCacheInhibitPin, extWriteThroughPin} ==
      $past({pageCacheInhibit, pageWriteThrough});
  endproperty
  a_hint: assert property (p_hint)
    else $error("hint pins wrong on paged cycle");
endmodule // flag_bank_sva

bind processor_control_flag_bank flag_bank_sva flag_bank_sva_inst (.*);

// [test/test_processor_control_flag_bank.sv]
// self-checking bench for the control flag bank
`include "cpu_ctrl_regs.vh"

module test_processor_control_flag_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, ce = 1, crWrEn = 0, insnValid = 0, insnFp = 0;
  logic insnWait = 0, insnPerfRead = 0, insnTimeRead = 0, insnDebugRef = 0;
  logic taskSwitch = 0, alignCheckFlag = 0, fpNumericErr = 0, accValid = 0;
  logic accWrite = 0, accSuper = 0, accUserPage = 0, accReadOnly = 0;
  logic nonPagedCycle = 0, pageCacheInhibit = 0, pageWriteThrough = 0;
  logic coproPresentPin = 0, hwErrorPin = 0;
  logic [2:0]  crWrSel = 0, crRdSel = 0, insnDebugNum = 0;
  logic [1:0]  insnCpl = 0;
  logic [31:0] crWrData = 0, d;
  wire  [31:0] crRdData;
  wire  [15:0] fpCtrlWordInit;
  wire  [7:0]  faultVector;
  wire  [5:0]  physAddrBits;
  wire  [1:0]  pageSizeMode;
  wire fpDispatch, faultValid, fpErrInternal, fpErrExternal, accBlocked;
  wire extCacheInhibitPin, extWriteThroughPin, tlbFlush, tlbKeepGlobal;
  wire wideTableFormat, cacheEnable, invalidateEnable, hitWriteThrough;
  wire alignCheckOn, v86VirtIntOn, protVirtIntOn;
  int failures = 0, num_checks = 0, rdPend = 0;
  logic [8:0]  insQ[$];
  logic [31:0] rdQ[$];

  processor_control_flag_bank processor_control_flag_bank_inst (.*);

  always #20 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic logic [8:0] flt(logic [7:0] v);
    return {1'b0, v};
  endfunction

  task automatic step;
    @(negedge clk);
  endtask

  task automatic wr(logic [2:0] s, logic [31:0] v);
    @(negedge clk);
    crWrEn = 1;
    crWrSel = s;
    crWrData = v;
    @(negedge clk);
    crWrEn = 0;
  endtask

  task automatic rd(logic [2:0] s, logic [31:0] e);
    @(negedge clk);
    crRdSel = s;
    rdQ.push_back(e);
    rdPend = 1;
  endtask

  // k: 0 fp, 1 wait, 2 perf read, 3 time read, 4 debug ref; e 0 = silent
  task automatic ins(int k, logic [1:0] c, logic [2:0] n, logic [8:0] e);
    @(negedge clk);
    {insnDebugRef, insnTimeRead, insnPerfRead, insnWait, insnFp} = 5'h1 << k;
    insnCpl = c;
    insnDebugNum = n;
    insnValid = 1;
    if (e != 0) insQ.push_back(e);
    @(negedge clk);
    insnValid = 0;
  endtask

  // results are matched against the oldest note
  always @(posedge clk) begin
    #1;
    if (rdPend) begin
      rdPend = 0;
      chk(crRdData, rdQ.pop_front());
    end
    if (fpDispatch !== 1'b0 || faultValid !== 1'b0) begin
      if (insQ.size() == 0) chk(32'h1, 32'h0);
      else chk({fpDispatch, fpDispatch ? 8'h0 : faultVector}, insQ.pop_front());
    end
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h8927));
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 0;
    rd(`SEL_SYSCTL, `SC_RESET);
    rd(`SEL_EXTCTL, `EX_RESET);
    chk(physAddrBits, `ADDR_NARROW);
    chk(fpCtrlWordInit, `FCW_ABSENT);
    coproPresentPin = 1;
    repeat (5) step;
    chk(fpCtrlWordInit, `FCW_PRESENT);
    for (int i = 0; i < 3; i++) begin
      d = $urandom;
      wr(3'h1, d);
      wr(`SEL_EXTCTL, d);
      rd(`SEL_EXTCTL, d & `EX_WMASK);
      wr(`SEL_PAGEBASE, d);
      rd(`SEL_PAGEBASE, d & `PB_WMASK);
      rd(3'h1, 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      wr(`SEL_SYSCTL, 32'h40000000 | (i << 1));
      ins(0, 0, 0, i[1] ? flt(`VEC_NODEV) : 9'h100);
      ins(1, 0, 0, 9'h0);
      @(negedge clk);
      taskSwitch = 1;
      @(negedge clk);
      taskSwitch = 0;
      ins(1, 0, 0, i[0] ? flt(`VEC_NODEV) : 9'h0);
      ins(0, 0, 0, flt(`VEC_NODEV));
    end
    for (int j = 0; j < 2; j++) begin
      wr(`SEL_EXTCTL, j ? 32'h100 : 32'h0c);
      for (int c = 0; c < 4; c += 3) begin
        ins(2, c, 0, (j || c == 0) ? 9'h0 : flt(`VEC_GPROT));
        ins(3, c, 0, (j || c == 0) ? 9'h0 : flt(`VEC_GPROT));
        ins(4, c, 4 + j, j ? 9'h0 : flt(`VEC_UNDEF));
      end
    end
    wr(`SEL_SYSCTL, 32'hc0010001);
    wr(`SEL_EXTCTL, 32'hb1);
    wr(`SEL_PAGEBASE, 32'h18);
    {nonPagedCycle, accValid, accWrite, accSuper, accUserPage} = 5'h1f;
    accReadOnly = 1;
    step;
    chk({physAddrBits, wideTableFormat, pageSizeMode}, 9'h126);
    chk({tlbKeepGlobal, v86VirtIntOn, cacheEnable}, 3'h6);
    chk({extCacheInhibitPin, extWriteThroughPin, accBlocked}, 3'h7);
    wr(`SEL_SYSCTL, 32'hc0000001);
    step;
    chk(accBlocked, 1'h0);
    wr(`SEL_EXTCTL, 32'h12);
    step;
    chk({physAddrBits, pageSizeMode, protVirtIntOn}, 9'h103);
    wr(`SEL_SYSCTL, 32'h40000000);
    chk(pageSizeMode, `PG_SMALL);
    insQ.push_back(flt(`VEC_GPROT));
    wr(`SEL_SYSCTL, 32'h20000000);
    rd(`SEL_SYSCTL, 32'h40000000);
    alignCheckFlag = 1;
    fpNumericErr = 1;
    wr(`SEL_SYSCTL, 32'h00040000);
    chk({cacheEnable, invalidateEnable, alignCheckOn}, 3'h7);
    chk({fpErrInternal, fpErrExternal}, 2'h1);
    wr(`SEL_EXTCTL, 32'h40);
    // a write while the enable is low must leave the register alone
    ce = 0;
    wr(`SEL_EXTCTL, 32'h1ff);
    ce = 1;
    rd(`SEL_EXTCTL, 32'h40);
    insQ.push_back(flt(`VEC_MCHK));
    hwErrorPin = 1;
    for (int t = 0; t < 20 && insQ.size() + rdPend > 0; t++) step;
    if (insQ.size() != 0) chk(32'h1, 32'h0);
    stop_test;
  end
endmodule // test_processor_control_flag_bank
